// ===== hdl/dac_clear_pkg.sv
package dac_clear_pkg;

	localparam int NUM_CHAN = 2;
	localparam int CODE_W = 16;
	localparam int SPAN_W = 4;
	localparam int STRAP_W = 3;

	// Power-up range: unipolar 0 V to 5 V
	localparam logic [3:0] SPAN_RESET = 4'h0;
	localparam logic [15:0] CODE_RESET = 16'h0000;

	// Synchroniser bit positions and their idle (reset) levels
	localparam int SYNC_W = 8;
	localparam int SB_CLEAR = 0;
	localparam int SB_SELECT = 1;
	localparam int SB_LOAD = 2;
	localparam int SB_BROWNOUT = 3;
	localparam int SB_MANUAL = 4;
	localparam int SB_STRAP = 5;
	localparam logic [7:0] SYNC_INIT = 8'h0f;

	typedef struct packed {
		logic [3:0] span;
		logic [15:0] code;
	} chan_t;

	// One-cycle command from the serial decoder, same clock
	typedef struct packed {
		logic write_en;
		logic is_code;
		logic update_en;
		logic [1:0] chan_mask;
		logic [15:0] data;
	} cmd_t;

endpackage : dac_clear_pkg

// ===== hdl/pin_sync3.sv
`timescale 1ns/1ns
`default_nettype none

module pin_sync3 #(
	parameter int W = 8,
	parameter logic [W-1:0] INIT = '1
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Raw pins and filtered levels
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level_q
);

	logic [W-1:0] ff1_q;
	logic [W-1:0] ff2_q;
	logic [W-1:0] ff3_q;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ff1_q <= INIT;
			ff2_q <= INIT;
			ff3_q <= INIT;
		end else begin
			ff1_q <= pin_in;
			ff2_q <= ff1_q;
			ff3_q <= ff2_q;
		end
	end

	// A change counts only once two later stages agree
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					level_q[i] <= INIT[i];
				end else if (ff2_q[i] == ff3_q[i]) begin
					level_q[i] <= ff3_q[i];
				end
			end
		end
	endgenerate

endmodule : pin_sync3

`default_nettype wire

// ===== hdl/dac_reset_clear_flag_logic.sv
// Overview of operation
// - Power-up sets every channel's range code to 0000, unipolar 0 to 5 V.
// - Power-up clears input and active registers to zero.
// - Strapped range reaches each channel at its first update after power-up.
// - Clear low resets all active registers to zero.
// - Clear leaves input span and code registers unchanged.
// - Any update after clear, serial or load pin, restores from input registers.
// - Clear during a framed instruction aborts that instruction.
// - Integrity flag goes low on power-up, clear and supply brown-out.
// - Integrity flag stays low until a valid update executes.
// - Update copies addressed input span and code into active registers.
// - Strapped configuration takes the active range from the strap pins.
`timescale 1ns/1ns
`default_nettype none

module dac_reset_clear_flag_logic (
	// Clock and power-on reset
	input wire logic mclk,
	input wire logic nrst,
	// Device pins
	input wire logic system_clear_n,
	input wire logic select_load_n,
	input wire logic async_load_n,
	input wire logic brownout_n,
	input wire logic manual_span,
	input wire logic [2:0] range_strap_pins,
	// Command from the serial decoder
	input wire dac_clear_pkg::cmd_t cmd,
	// Register contents
	output dac_clear_pkg::chan_t [1:0] input_regs_q,
	output dac_clear_pkg::chan_t [1:0] active_regs_q,
	// Status
	output logic integrity_lost_flag_n,
	output logic instr_abort_q,
	output logic shift_restart_q
);

	logic [dac_clear_pkg::SYNC_W-1:0] pins_q;
	logic clear_rst_n;
	logic load_prev_q;
	logic load_fall;
	logic cmd_ok;
	logic [1:0] upd_mask;
	logic [3:0] strap_span;
	dac_clear_pkg::chan_t [1:0] input_d;

	pin_sync3 #(
		.W(dac_clear_pkg::SYNC_W),
		.INIT(dac_clear_pkg::SYNC_INIT)
	) u_sync (
		.mclk(mclk),
		.nrst(nrst),
		.pin_in({range_strap_pins, manual_span, brownout_n, async_load_n,
			select_load_n, system_clear_n}),
		.level_q(pins_q)
	);

	// Clear acts without the clock, like power-on reset
	assign clear_rst_n = nrst & system_clear_n;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			load_prev_q <= 1'b1;
		end else begin
			load_prev_q <= pins_q[dac_clear_pkg::SB_LOAD];
		end
	end

	assign load_fall = load_prev_q & ~pins_q[dac_clear_pkg::SB_LOAD];

	// Abort: clear seen while the frame is open
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			instr_abort_q <= 1'b0;
		end else if (!pins_q[dac_clear_pkg::SB_CLEAR] && !pins_q[dac_clear_pkg::SB_SELECT]) begin
			instr_abort_q <= 1'b1;
		end else if (pins_q[dac_clear_pkg::SB_SELECT]) begin
			instr_abort_q <= 1'b0;
		end
	end

	// One pulse telling the shifter to drop its partial word
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			shift_restart_q <= 1'b0;
		end else begin
			shift_restart_q <= pins_q[dac_clear_pkg::SB_SELECT] & instr_abort_q;
		end
	end

	assign cmd_ok = ~instr_abort_q & pins_q[dac_clear_pkg::SB_CLEAR] & system_clear_n;
	assign strap_span = {1'b0, pins_q[dac_clear_pkg::SB_STRAP +: dac_clear_pkg::STRAP_W]};
	// The load pin updates all channels; a serial update only the addressed ones
	assign upd_mask = (cmd.update_en && cmd_ok ? cmd.chan_mask : 2'b00) |
		{2{load_fall}};

	always_comb begin
		input_d = input_regs_q;
		for (int c = 0; c < dac_clear_pkg::NUM_CHAN; c++) begin
			if (cmd.write_en && cmd_ok && cmd.chan_mask[c]) begin
				if (cmd.is_code) begin
					input_d[c].code = cmd.data;
				end else begin
					input_d[c].span = cmd.data[3:0];
				end
			end
		end
	end

	// Input registers see power-on only, never clear
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			for (int c = 0; c < dac_clear_pkg::NUM_CHAN; c++) begin
				input_regs_q[c].span <= dac_clear_pkg::SPAN_RESET;
				input_regs_q[c].code <= dac_clear_pkg::CODE_RESET;
			end
		end else begin
			input_regs_q <= input_d;
		end
	end

	genvar g;
	generate
		for (g = 0; g < dac_clear_pkg::NUM_CHAN; g++) begin : g_chan
			always_ff @(posedge mclk or negedge clear_rst_n) begin
				if (!clear_rst_n) begin
					active_regs_q[g].span <= dac_clear_pkg::SPAN_RESET;
					active_regs_q[g].code <= dac_clear_pkg::CODE_RESET;
				end else if (upd_mask[g]) begin
					// Write-and-update commands pass the new value straight through
					active_regs_q[g].code <= input_d[g].code;
					if (pins_q[dac_clear_pkg::SB_MANUAL]) begin
						active_regs_q[g].span <= strap_span;
					end else begin
						active_regs_q[g].span <= input_d[g].span;
					end
				end
			end
		end
	endgenerate

	// Brown-out wins over a same-cycle update so the loss is never hidden
	always_ff @(posedge mclk or negedge clear_rst_n) begin
		if (!clear_rst_n) begin
			integrity_lost_flag_n <= 1'b0;
		end else if (!pins_q[dac_clear_pkg::SB_BROWNOUT]) begin
			integrity_lost_flag_n <= 1'b0;
		end else if (upd_mask != 2'b00) begin
			integrity_lost_flag_n <= 1'b1;
		end
	end

	property p_flag_release;
		@(posedge mclk) disable iff (!clear_rst_n)
		(upd_mask != 2'b00) && pins_q[dac_clear_pkg::SB_BROWNOUT] |=> integrity_lost_flag_n;
	endproperty
	a_flag_release: assert property (p_flag_release) else $error("flag not released by update");

	property p_flag_hold;
		@(posedge mclk) disable iff (!clear_rst_n)
		!integrity_lost_flag_n && (upd_mask == 2'b00) |=> !integrity_lost_flag_n;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag released without update");

	property p_flag_brownout;
		@(posedge mclk) disable iff (!clear_rst_n)
		!pins_q[dac_clear_pkg::SB_BROWNOUT] |=> !integrity_lost_flag_n;
	endproperty
	a_flag_brownout: assert property (p_flag_brownout) else $error("brown-out missed flag");

	property p_clear_zero;
		@(posedge mclk) disable iff (!nrst)
		!system_clear_n |-> active_regs_q[0] == '0 && active_regs_q[1] == '0 &&
			!integrity_lost_flag_n;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("clear left active data");

	property p_input_kept;
		@(posedge mclk) disable iff (!nrst)
		!pins_q[dac_clear_pkg::SB_CLEAR] |=> $stable(input_regs_q);
	endproperty
	a_input_kept: assert property (p_input_kept) else $error("clear changed input regs");

	property p_update_copy;
		@(posedge mclk) disable iff (!clear_rst_n)
		upd_mask[1] && !pins_q[dac_clear_pkg::SB_MANUAL] |=> active_regs_q[1] == input_regs_q[1];
	endproperty
	a_update_copy: assert property (p_update_copy) else $error("update did not copy");

	property p_strap_span;
		@(posedge mclk) disable iff (!clear_rst_n)
		upd_mask[0] && pins_q[dac_clear_pkg::SB_MANUAL] |=>
			active_regs_q[0].span == $past(strap_span);
	endproperty
	a_strap_span: assert property (p_strap_span) else $error("strap span not applied");

	property p_abort;
		@(posedge mclk) disable iff (!nrst)
		!pins_q[dac_clear_pkg::SB_CLEAR] && !pins_q[dac_clear_pkg::SB_SELECT] |=> instr_abort_q;
	endproperty
	a_abort: assert property (p_abort) else $error("frame not aborted on clear");

	// The abort must last until the frame closes, or the shifter resumes a broken word
	property p_abort_hold;
		@(posedge mclk) disable iff (!nrst)
		instr_abort_q && !pins_q[dac_clear_pkg::SB_SELECT] |=> instr_abort_q;
	endproperty
	a_abort_hold: assert property (p_abort_hold) else $error("abort dropped inside frame");

	property p_refused;
		@(posedge mclk) disable iff (!nrst)
		!cmd_ok |=> $stable(input_regs_q);
	endproperty
	a_refused: assert property (p_refused) else $error("refused command wrote input regs");

	property p_restart;
		@(posedge mclk) disable iff (!nrst)
		instr_abort_q && pins_q[dac_clear_pkg::SB_SELECT] |=> shift_restart_q ##1 !instr_abort_q;
	endproperty
	a_restart: assert property (p_restart) else $error("no shifter restart after abort");

	property p_restart_once;
		@(posedge mclk) disable iff (!nrst)
		shift_restart_q |=> !shift_restart_q;
	endproperty
	a_restart_once: assert property (p_restart_once) else $error("restart pulse too long");

endmodule : dac_reset_clear_flag_logic

`default_nettype wire

// ===== tb/host_model.sv
`timescale 1ns/1ns
`default_nettype none

module host_model (
	// Clock
	input wire logic mclk,
	// Toward the block
	output dac_clear_pkg::cmd_t cmd,
	output logic select_load_n
);
	initial begin
		cmd = '0;
		select_load_n = 1'b1;
	end

	// Presents one command at a negedge, holds it for one clock edge, then returns cmd to zero
	task automatic send(input logic wr, input logic cd, input logic up,
		input logic [1:0] m, input logic [15:0] d);
		@(negedge mclk);
		cmd <= '{wr, cd, up, m, d};
		@(negedge mclk);
		cmd <= '0;
	endtask : send

	task automatic frame(input logic low);
		@(negedge mclk);
		select_load_n <= ~low;
	endtask : frame
endmodule : host_model

`default_nettype wire

// ===== tb/dac_reset_clear_flag_logic_test.sv
`timescale 1ns/1ns
`default_nettype none

module dac_reset_clear_flag_logic_test;
	// Starting low avoids a false falling edge at time zero
	logic mclk = 1'b0;
	logic nrst, clr_n, ld_n, bo_n, man, sel_n, fl_n, ab, rs;
	logic [2:0] strap;
	logic [3:0] seen;
	dac_clear_pkg::cmd_t cmd;
	dac_clear_pkg::chan_t [1:0] inp, act;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;

	dac_reset_clear_flag_logic dut_u (.mclk(mclk), .nrst(nrst), .system_clear_n(clr_n),
		.select_load_n(sel_n), .async_load_n(ld_n), .brownout_n(bo_n), .manual_span(man),
		.range_strap_pins(strap), .cmd(cmd), .input_regs_q(inp), .active_regs_q(act),
		.integrity_lost_flag_n(fl_n), .instr_abort_q(ab), .shift_restart_q(rs));
	host_model host_u (.mclk(mclk), .cmd(cmd), .select_load_n(sel_n));

	initial begin
		forever #10 mclk = ~mclk;
	end

	// Whole sequence needs well under 300 cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			num_errors++;
			final_report();
		end
	end

	task automatic check(input logic [19:0] s, input logic [19:0] e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : check

	// Pins pass a synchroniser, so allow it to settle
	task automatic sync();
		repeat (6) @(negedge mclk);
	endtask : sync

	task automatic final_report();
		if (num_errors == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report

	initial begin
		nrst = 1'b0;
		clr_n = 1'b1;
		ld_n = 1'b1;
		bo_n = 1'b1;
		man = 1'b0;
		strap = 3'h0;
		repeat (2) @(negedge mclk);
		nrst = 1'b1;
		check(act[1], 20'h00000);
		check(inp[1], 20'h00000);
		check(fl_n, 20'h0);
		sync();
		host_u.send(1'b1, 1'b1, 1'b0, 2'h1, 16'h1234);
		host_u.send(1'b1, 1'b0, 1'b0, 2'h1, 16'h0003);
		host_u.send(1'b1, 1'b1, 1'b0, 2'h2, 16'hbeef);
		check(fl_n, 20'h0);
		host_u.send(1'b0, 1'b0, 1'b1, 2'h1, 16'h0000);
		check(act[0], 20'h31234);
		check(act[1], 20'h00000);
		check(fl_n, 20'h1);
		clr_n = 1'b0;
		#1;
		check(act[0], 20'h00000);
		check(fl_n, 20'h0);
		@(negedge mclk);
		clr_n = 1'b1;
		check(inp[1], 20'h0beef);
		sync();
		ld_n = 1'b0;
		sync();
		ld_n = 1'b1;
		check(act[0], 20'h31234);
		check(act[1], 20'h0beef);
		check(fl_n, 20'h1);
		host_u.frame(1'b1);
		clr_n = 1'b0;
		sync();
		check(ab, 20'h1);
		clr_n = 1'b1;
		sync();
		host_u.send(1'b1, 1'b1, 1'b1, 2'h3, 16'h5555);
		check(inp[0], 20'h31234);
		check(act[0], 20'h00000);
		host_u.frame(1'b0);
		seen = 4'h0;
		repeat (8) begin
			@(negedge mclk);
			seen = seen + rs;
		end
		check(seen, 20'h1);
		check(ab, 20'h0);
		host_u.send(1'b1, 1'b1, 1'b0, 2'h3, 16'h5555);
		check(inp[1], 20'h05555);
		man = 1'b1;
		strap = 3'h5;
		sync();
		host_u.send(1'b0, 1'b0, 1'b1, 2'h3, 16'h0000);
		check(act[0], 20'h55555);
		check(act[1], 20'h55555);
		bo_n = 1'b0;
		sync();
		check(fl_n, 20'h0);
		host_u.send(1'b0, 1'b0, 1'b1, 2'h3, 16'h0000);
		check(fl_n, 20'h0);
		bo_n = 1'b1;
		sync();
		host_u.send(1'b0, 1'b0, 1'b1, 2'h1, 16'h0000);
		check(fl_n, 20'h1);
		nrst = 1'b0;
		#1;
		check(inp[0], 20'h00000);
		check(act[0], 20'h00000);
		final_report();
	end
endmodule : dac_reset_clear_flag_logic_test

`default_nettype wire
